// ---- core/pll_status_consts.svh ----
// register map, field positions, reset values and selection codes of the status pin selector
`ifndef PLL_STATUS_CONSTS_SVH
`define PLL_STATUS_CONSTS_SVH

// register indices, byte address is four times the index
`define REG_PRESCALE_IDX    6'h16
`define REG_STATUS_SEL_IDX  6'h17
`define REG_INT_STATUS_IDX  6'h18
`define REG_INT_MASK_IDX    6'h19
`define REG_LIVE_STATE_IDX  6'h1A

// field positions
`define SEL_MSB             7
`define SEL_LSB             2
`define PRE_MSB             2
`define PRE_LSB             0

// reset values
`define STATUS_SEL_RESET    6'h00
`define PRESCALE_RESET      3'h0
`define INT_MASK_RESET      4'h0

// interrupt status bit positions
`define INT_LOCK_CHANGE     0
`define INT_HOLDOVER_ENTER  1
`define INT_REF_SWITCH      2
`define INT_FREQ_FAULT      3

// select codes with the top bit clear
`define SEL_GROUND          6'h00
`define SEL_N_DIV           6'h01
`define SEL_R_DIV           6'h02
`define SEL_A_DIV           6'h03
`define SEL_PRESCALER       6'h04
`define SEL_PFD_UP          6'h05
`define SEL_PFD_DOWN        6'h06

// monitor codes, low four bits of a select code with the top bit set, zero extended to five
`define MON_GROUND          5'h00
`define MON_FIRST_REFERENCE_INPUT_CLK        5'h01
`define MON_SECOND_REFERENCE_INPUT_CLK        5'h02
`define MON_SEL_CLK         5'h03
`define MON_UNSEL_CLK       5'h04
`define MON_SEL_OK          5'h05
`define MON_UNSEL_OK        5'h06
`define MON_FIRST_REFERENCE_INPUT_FREQ       5'h07
`define MON_SECOND_REFERENCE_INPUT_FREQ       5'h08
`define MON_BOTH_FREQ       5'h09
`define MON_ALL_LOCKED      5'h0A
`define MON_VCO_FREQ        5'h0B
`define MON_REF_IN_USE      5'h0C
`define MON_LOCK            5'h0D
`define MON_HOLDOVER        5'h0E

// prescaler moduli
`define DIV_BY_1            6'h01
`define DIV_BY_2            6'h02
`define DIV_BY_3            6'h03
`define DIV_BY_4            6'h04
`define DIV_BY_5            6'h05
`define DIV_BY_8            6'h08
`define DIV_BY_9            6'h09
`define DIV_BY_16           6'h10
`define DIV_BY_17           6'h11
`define DIV_BY_32           6'h20
`define DIV_BY_33           6'h21

`endif

// ---- core/pll_status_pkg.sv ----
// types shared by the status pin selector
package pll_status_pkg;

    // prescaler mode codes
    typedef enum logic [2:0] {
        PRE_FD1  = 3'b000,
        PRE_FD2  = 3'b001,
        PRE_DM3  = 3'b010,
        PRE_DM5  = 3'b011,
        PRE_DM9  = 3'b100,
        PRE_DM17 = 3'b101,
        PRE_DM33 = 3'b110,
        PRE_FD3  = 3'b111
    } prescale_mode_type;

    // whole state of the selector
    typedef struct packed {
        logic              waitReq;
        logic [31:0]       readData;
        logic [5:0]        statusSel;
        prescale_mode_type prescale;
        logic [3:0]        intStatus;
        logic [3:0]        intMask;
        logic              irq;
        logic              pin;
        logic [5:0]        preCount;
        logic              preOut;
        logic              prevLock;
        logic              prevHold;
        logic              prevRef;
        logic              prevFreqOk;
    } selector_state_type;

endpackage

// ---- core/pin_sync.sv ----
// three-stage synchroniser whose output follows once the last two stages agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_type;

    sync_type s_r;
    sync_type s_nxt;

    // shift the chain, take each bit only where stages two and three agree
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = asyncIn;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        s_nxt.q  = (s_r.s2 & s_r.s3) | (s_r.q & (s_r.s2 | s_r.s3));
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign syncOut = s_r.q;

endmodule

// ---- core/pll_status_pin_select.sv ----
// status pin selector of the clock generator PLL with prescaler modulus decode
//
// Operation
// RQ1: prescaler codes divide by 5 or 4, and 9 or 8, per A counter zero
// RQ2: prescaler codes divide by 17 or 16, and 33 or 32, per A counter zero
// RQ3: bits 7 to 2 of register 0x17 select the status pin source
// RQ4: code zero and unlisted codes with top bit clear drive the pin low
// RQ5: codes 1 to 6 route divider, prescaler and phase detector pulses
// RQ6: top-bit codes mirror the monitor set; 100000 low, 100001 first reference
// RQ7: code 100010 drives second reference, unavailable in differential mode
// RQ8: 100011 selected reference, 100100 unselected reference, latter not differential
// RQ9: 100101 and 100110 show selected and unselected reference status, high
// RQ10: 100111 and 101000 show first and second reference frequency status
// RQ11: 101001 shows both reference frequency statuses ANDed
// RQ12: 101010 ANDs lock, selected status and VCO; 101011 VCO status alone
// RQ13: 101100 shows reference in use, low first, high second
// RQ14: 101101 shows digital lock as an active high level
// RQ15: 101110 shows holdover as an active high level
// RQ16: top two bits set repeat monitor levels inverted, reference in use inverted
// RQ17: toggling selections pass the live signal, level selections a steady state
`timescale 1ns/1ps
`include "pll_status_consts.svh"
module pll_status_pin_select
    import pll_status_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    // register bus
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // signals of the PLL core
    input  wire logic        nDividerOut,
    input  wire logic        rDividerOut,
    input  wire logic        aDividerOut,
    input  wire logic        pfdUpPulse,
    input  wire logic        pfdDownPulse,
    input  wire logic        firstReferenceInput,
    input  wire logic        secondReferenceInput,
    input  wire logic        firstRefFreqOk,
    input  wire logic        secondRefFreqOk,
    input  wire logic        vcoFreqOk,
    input  wire logic        digitalLockFlag,
    input  wire logic        holdoverActive,
    input  wire logic        secondRefInUse,
    input  wire logic        differentialRef,
    input  wire logic        aCounterZero,
    // outputs
    output logic             statusPin,
    output logic             prescalerOut,
    output logic             irq
);

    selector_state_type s_r;
    selector_state_type s_nxt;

    logic [14:0] syncBus;
    logic        nDiv;
    logic        rDiv;
    logic        aDiv;
    logic        pfdUp;
    logic        pfdDown;
    logic        ref1Clk;
    logic        ref2Clk;
    logic        ref1Ok;
    logic        ref2Ok;
    logic        vcoOk;
    logic        locked;
    logic        holdover;
    logic        ref2InUse;
    logic        diffMode;
    logic        aZero;

    logic [5:0]  modulus;
    logic        selClk;
    logic        unselClk;
    logic        selOk;
    logic        unselOk;
    logic        monLevel;
    logic        monToggling;
    logic        pinValue;
    logic [5:0]  regIdx;
    logic [3:0]  events;
    logic [31:0] readValue;

    // every input from the PLL core crosses into the bus clock domain
    pin_sync #(
        .WIDTH (15)
    ) inputSync (
        .clk     (clk),
        .reset   (reset),
        .asyncIn ({nDividerOut, rDividerOut, aDividerOut, pfdUpPulse, pfdDownPulse,
                   firstReferenceInput, secondReferenceInput, firstRefFreqOk,
                   secondRefFreqOk, vcoFreqOk, digitalLockFlag, holdoverActive,
                   secondRefInUse, differentialRef, aCounterZero}),
        .syncOut (syncBus)
    );

    assign {nDiv, rDiv, aDiv, pfdUp, pfdDown, ref1Clk, ref2Clk, ref1Ok, ref2Ok, vcoOk,
            locked, holdover, ref2InUse, diffMode, aZero} = syncBus;

    // prescaler modulus from mode and A counter
    always_comb begin
        unique case (s_r.prescale)
            PRE_FD1:  modulus = `DIV_BY_1;
            PRE_FD2:  modulus = `DIV_BY_2;
            PRE_DM3:  modulus = aZero ? `DIV_BY_2 : `DIV_BY_3;
            PRE_DM5:  modulus = aZero ? `DIV_BY_4 : `DIV_BY_5;   // RQ1
            PRE_DM9:  modulus = aZero ? `DIV_BY_8 : `DIV_BY_9;   // RQ1
            PRE_DM17: modulus = aZero ? `DIV_BY_16 : `DIV_BY_17; // RQ2
            PRE_DM33: modulus = aZero ? `DIV_BY_32 : `DIV_BY_33; // RQ2
            PRE_FD3:  modulus = `DIV_BY_3;
        endcase
    end

    // selected and unselected reference views; differential mode has no second one
    always_comb begin
        selClk   = ref2InUse ? ref2Clk : ref1Clk;                 // RQ8
        unselClk = diffMode ? 1'b0 : (ref2InUse ? ref1Clk : ref2Clk); // RQ8
        selOk    = ref2InUse ? ref2Ok : ref1Ok;                   // RQ9
        unselOk  = diffMode ? 1'b0 : (ref2InUse ? ref1Ok : ref2Ok);   // RQ9
    end

    // monitor selection shared by both top-bit code groups
    always_comb begin
        monToggling = 1'b0;
        unique case ({1'b0, s_r.statusSel[3:0]})
            `MON_GROUND:     monLevel = 1'b0;                        // RQ6
            `MON_FIRST_REFERENCE_INPUT_CLK: begin
                monLevel    = ref1Clk;                               // RQ6
                monToggling = 1'b1;
            end
            `MON_SECOND_REFERENCE_INPUT_CLK: begin
                monLevel    = diffMode ? 1'b0 : ref2Clk;             // RQ7
                monToggling = 1'b1;
            end
            `MON_SEL_CLK: begin
                monLevel    = selClk;                                // RQ8
                monToggling = 1'b1;
            end
            `MON_UNSEL_CLK: begin
                monLevel    = unselClk;                              // RQ8
                monToggling = 1'b1;
            end
            `MON_SEL_OK:     monLevel = selOk;                       // RQ9
            `MON_UNSEL_OK:   monLevel = unselOk;                     // RQ9
            `MON_FIRST_REFERENCE_INPUT_FREQ:  monLevel = ref1Ok;                      // RQ10
            `MON_SECOND_REFERENCE_INPUT_FREQ:  monLevel = ref2Ok;                      // RQ10
            `MON_BOTH_FREQ:  monLevel = ref1Ok & ref2Ok;             // RQ11
            `MON_ALL_LOCKED: monLevel = locked & selOk & vcoOk;      // RQ12
            `MON_VCO_FREQ:   monLevel = vcoOk;                       // RQ12
            `MON_REF_IN_USE: monLevel = ref2InUse;                   // RQ13
            `MON_LOCK:       monLevel = locked;                      // RQ14
            `MON_HOLDOVER:   monLevel = holdover;                    // RQ15
            default:         monLevel = 1'b0;
        endcase
    end

    // pin source: toggling choices pass live, level choices may be inverted
    always_comb begin
        if (!s_r.statusSel[5]) begin
            unique case (s_r.statusSel)
                `SEL_N_DIV:     pinValue = nDiv;                     // RQ5 RQ17
                `SEL_R_DIV:     pinValue = rDiv;                     // RQ5
                `SEL_A_DIV:     pinValue = aDiv;                     // RQ5
                `SEL_PRESCALER: pinValue = s_r.preOut;               // RQ5
                `SEL_PFD_UP:    pinValue = pfdUp;                    // RQ5
                `SEL_PFD_DOWN:  pinValue = pfdDown;                  // RQ5
                default:        pinValue = 1'b0;                     // RQ4
            endcase
        end else if (s_r.statusSel[4] && !monToggling) begin
            pinValue = ~monLevel;                                    // RQ16
        end else begin
            pinValue = monLevel;                                     // RQ6 RQ17
        end
    end

    // monitor events that raise interrupt status
    always_comb begin
        events                      = '0;
        events[`INT_LOCK_CHANGE]    = locked ^ s_r.prevLock;
        events[`INT_HOLDOVER_ENTER] = holdover & ~s_r.prevHold;
        events[`INT_REF_SWITCH]     = ref2InUse ^ s_r.prevRef;
        events[`INT_FREQ_FAULT]     = s_r.prevFreqOk & ~(ref1Ok & ref2Ok);
    end

    // register read mux, unmapped indices read as zero
    assign regIdx = address[7:2];

    always_comb begin
        readValue = '0;
        unique case (regIdx)
            `REG_PRESCALE_IDX:   readValue[`PRE_MSB:`PRE_LSB] = s_r.prescale;
            `REG_STATUS_SEL_IDX: readValue[`SEL_MSB:`SEL_LSB] = s_r.statusSel;
            `REG_INT_STATUS_IDX: readValue[3:0] = s_r.intStatus;
            `REG_INT_MASK_IDX:   readValue[3:0] = s_r.intMask;
            `REG_LIVE_STATE_IDX: readValue[7:0] = {s_r.pin, s_r.preOut, modulus};
            default:             readValue = '0;
        endcase
    end

    // next state: bus handshake, register writes, prescaler, pin and interrupts
    always_comb begin
        s_nxt            = s_r;
        s_nxt.prevLock   = locked;
        s_nxt.prevHold   = holdover;
        s_nxt.prevRef    = ref2InUse;
        s_nxt.prevFreqOk = ref1Ok & ref2Ok;
        s_nxt.pin        = pinValue;

        // prescaler counter gives one pulse every modulus cycles
        if (s_r.preCount + 6'h01 >= modulus) begin
            s_nxt.preCount = 6'h00;
            s_nxt.preOut   = 1'b1;
        end else begin
            s_nxt.preCount = s_r.preCount + 6'h01;
            s_nxt.preOut   = 1'b0;
        end

        // one wait cycle, then the answer stands for the accepting edge
        if ((read || write) && s_r.waitReq) begin
            s_nxt.waitReq  = 1'b0;
            s_nxt.readData = read ? readValue : '0;
        end else begin
            s_nxt.waitReq  = 1'b1;
        end

        // writes take effect at the edge that samples waitrequest low
        if (write && !s_r.waitReq && byteenable[0]) begin
            if (regIdx == `REG_STATUS_SEL_IDX) begin
                s_nxt.statusSel = writedata[`SEL_MSB:`SEL_LSB];     // RQ3
            end
            if (regIdx == `REG_PRESCALE_IDX) begin
                s_nxt.prescale = prescale_mode_type'(writedata[`PRE_MSB:`PRE_LSB]);
            end
            if (regIdx == `REG_INT_MASK_IDX) begin
                s_nxt.intMask = writedata[3:0];
            end
        end

        // a status read clears only bits it returned; new events win
        if (read && !s_r.waitReq && regIdx == `REG_INT_STATUS_IDX) begin
            s_nxt.intStatus = (s_r.intStatus & ~s_r.readData[3:0]) | events;
        end else begin
            s_nxt.intStatus = s_r.intStatus | events;
        end
        s_nxt.irq = |(s_nxt.intStatus & s_nxt.intMask);
    end

    // state register with first-cycle sampled levels assumed low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r            <= '0;
            s_r.waitReq    <= 1'b1;
            s_r.statusSel  <= `STATUS_SEL_RESET;
            s_r.prescale   <= prescale_mode_type'(`PRESCALE_RESET);
            s_r.intMask    <= `INT_MASK_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign readdata     = s_r.readData;
    assign waitrequest  = s_r.waitReq;
    assign statusPin    = s_r.pin;
    assign prescalerOut = s_r.preOut;
    assign irq          = s_r.irq;

    // checks of the selector against its inputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence selWriteSeq;
        write && !waitrequest && byteenable[0] && regIdx == `REG_STATUS_SEL_IDX;
    endsequence

    sequence selStableSeq(logic [5:0] code);
        s_r.statusSel == code ##1 s_r.statusSel == code;
    endsequence

    AST_SEL_WRITE: assert property ( // RQ3
        selWriteSeq |=> s_r.statusSel == $past(writedata[7:2]))
        else $error("select field did not take written value");

    AST_GROUND: assert property ( // RQ4
        !s_r.statusSel[5] && s_r.statusSel > `SEL_PFD_DOWN |=> !statusPin)
        else $error("unlisted low code did not drive pin low");

    AST_N_DIV: assert property ( // RQ5
        s_r.statusSel == `SEL_N_DIV |=> statusPin == $past(nDiv))
        else $error("N divider not routed to pin");

    AST_SECOND_REFERENCE_INPUT_DIFF: assert property ( // RQ7
        s_r.statusSel == 6'h22 && diffMode |=> !statusPin)
        else $error("second reference shown in differential mode");

    AST_BOTH_FREQ: assert property ( // RQ11
        s_r.statusSel == 6'h29 |=> statusPin == $past(ref1Ok & ref2Ok))
        else $error("frequency AND not on pin");

    AST_HOLDOVER: assert property ( // RQ15
        selStableSeq(6'h2E) |-> statusPin == $past(holdover))
        else $error("holdover level not on pin");

    AST_LOCK_INVERTED: assert property ( // RQ16
        selStableSeq(6'h3D) |-> statusPin == !$past(locked))
        else $error("inverted lock level wrong");

    AST_GROUND_ZERO: assert property ( // RQ4
        s_r.statusSel == `SEL_GROUND |=> !statusPin)
        else $error("ground code did not drive pin low");

    AST_FIRST_REFERENCE_INPUT_CLK: assert property ( // RQ6
        selStableSeq(6'h21) |-> statusPin == $past(ref1Clk))
        else $error("first reference clock not on pin");

    AST_REF_IN_USE: assert property ( // RQ13
        selStableSeq(6'h2C) |-> statusPin == $past(ref2InUse))
        else $error("reference in use level wrong");

    AST_LOCK: assert property ( // RQ14
        selStableSeq(6'h2D) |-> statusPin == $past(locked))
        else $error("lock level not on pin");

    AST_DM5: assert property ( // RQ1
        s_r.prescale == PRE_DM5 |-> modulus == (aZero ? 6'h04 : 6'h05))
        else $error("prescaler 5 or 4 modulus wrong");

    AST_DM33: assert property ( // RQ2
        s_r.prescale == PRE_DM33 |-> modulus == (aZero ? 6'h20 : 6'h21))
        else $error("prescaler 33 or 32 modulus wrong");

    // modulus must hold at five over the whole period, a late A counter change is legal
    sequence dm5FiveSeq;
        (s_r.prescale == PRE_DM5 && modulus == `DIV_BY_5) [*5];
    endsequence

    AST_PRE_PERIOD: assert property ( // RQ1
        prescalerOut ##0 dm5FiveSeq |=> prescalerOut && !$past(prescalerOut) &&
        !$past(prescalerOut, 2) && !$past(prescalerOut, 3) && !$past(prescalerOut, 4))
        else $error("prescaler period not five cycles");

endmodule

// ---- verification/pll_core_model.sv ----
// behavioural model of the PLL core signals seen by the status pin selector
`timescale 1ns/1ps
module pll_core_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [6:0] runMask,
    input  wire logic [6:0] holdVal,
    output logic      [6:0] sig
);
    logic [3:0] cnt_r;

    // running sources toggle every eight cycles, held ones sit at their level
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 4'h0;
            sig   <= 7'h00;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            sig   <= (runMask & {7{cnt_r[3]}}) | (~runMask & holdVal);
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the status pin selector
`timescale 1ns/1ps
`include "pll_status_consts.svh"
module tb_top;
    logic        clk;
    logic        reset;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [6:0]  runMask;
    logic [6:0]  holdVal;
    logic [6:0]  src;
    logic [6:0]  lv;
    logic        aZero;
    logic        statusPin;
    logic        prescalerOut;
    logic        irq;
    logic [31:0] q;
    logic [13:0] pat [4];
    logic [5:0]  dynCode [7];
    int          badCount;
    int          cmpCount;

    // free running clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    pll_core_model core_u (.clk(clk), .reset(reset), .runMask(runMask), .holdVal(holdVal),
        .sig(src));

    pll_status_pin_select dut_u (.clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .nDividerOut(src[0]), .rDividerOut(src[1]),
        .aDividerOut(src[2]), .pfdUpPulse(src[3]), .pfdDownPulse(src[4]),
        .firstReferenceInput(src[5]), .secondReferenceInput(src[6]),
        .firstRefFreqOk(lv[0]), .secondRefFreqOk(lv[1]), .vcoFreqOk(lv[2]),
        .digitalLockFlag(lv[3]), .holdoverActive(lv[4]), .secondRefInUse(lv[5]),
        .differentialRef(lv[6]), .aCounterZero(aZero), .statusPin(statusPin),
        .prescalerOut(prescalerOut), .irq(irq));

    // counts and verdict, the single end of the run
    task automatic reportAndStop();
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
        int n;
        address <= {idx, 2'b00};
        write <= wr;
        read <= ~wr;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            badCount++;
            reportAndStop();
        end
    endtask

    // spacing of two prescaler pulses in clock cycles
    task automatic period(output int n);
        int k;
        k = 0;
        while (prescalerOut !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prescalerOut !== 1'b1 && n < 100);
        if (k >= 100 || n >= 100) begin
            badCount++;
            reportAndStop();
        end
    endtask

    function automatic logic [31:0] expMod(input int m, input logic az);
        case (m)
            0:       return 1;
            1:       return 2;
            2:       return az ? 2 : 3;
            3:       return az ? 4 : 5;
            4:       return az ? 8 : 9;
            5:       return az ? 16 : 17;
            6:       return az ? 32 : 33;
            default: return 3;
        endcase
    endfunction

    // expected pin for static sources s and levels v
    function automatic logic expPin(input logic [5:0] c, input logic [6:0] s,
                                    input logic [6:0] v);
        logic sc;
        logic uc;
        logic so;
        logic uo;
        logic r;
        sc = v[5] ? s[6] : s[5];
        uc = v[6] ? 1'b0 : (v[5] ? s[5] : s[6]);
        so = v[5] ? v[1] : v[0];
        uo = v[6] ? 1'b0 : (v[5] ? v[0] : v[1]);
        if (!c[5]) begin
            case (c)
                6'h01:   return s[0];
                6'h02:   return s[1];
                6'h03:   return s[2];
                6'h04:   return 1'b1;
                6'h05:   return s[3];
                6'h06:   return s[4];
                default: return 1'b0;
            endcase
        end
        case (c[3:0])
            4'h1:    r = s[5];
            4'h2:    r = v[6] ? 1'b0 : s[6];
            4'h3:    r = sc;
            4'h4:    r = uc;
            4'h5:    r = so;
            4'h6:    r = uo;
            4'h7:    r = v[0];
            4'h8:    r = v[1];
            4'h9:    r = v[0] & v[1];
            4'hA:    r = v[3] & so & v[2];
            4'hB:    r = v[2];
            4'hC:    r = v[5];
            4'hD:    r = v[3];
            4'hE:    r = v[4];
            default: r = 1'b0;
        endcase
        if (c[4] && !(c[3:0] inside {[1:4]})) begin
            r = ~r;
        end
        return r;
    endfunction

    initial begin
        int n;
        int t;
        logic prev;
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        runMask = 7'h00;
        holdVal = 7'h00;
        lv = 7'h00;
        aZero = 1'b0;
        badCount = 0;
        cmpCount = 0;
        pat = '{{7'h55, 7'h2B}, {7'h2A, 7'h1C}, {7'h7F, 7'h47}, {7'h00, 7'h3F}};
        dynCode = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h21, 6'h22};
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // reset values, unmapped index and select field readback
        cmp(statusPin, 0);
        bus(1'b0, `REG_STATUS_SEL_IDX, 0);
        cmp(q, 0);
        bus(1'b0, `REG_PRESCALE_IDX, 0);
        cmp(q, 0);
        bus(1'b0, `REG_INT_MASK_IDX, 0);
        cmp(q, 0);
        bus(1'b1, 6'h3F, 32'hFF);
        bus(1'b0, 6'h3F, 0);
        cmp(q, 0);
        bus(1'b1, `REG_STATUS_SEL_IDX, 32'hFF);
        bus(1'b0, `REG_STATUS_SEL_IDX, 0);
        cmp(q, 32'hFC);
        $display("test registers done");
        // every select code under four static input patterns
        for (int p = 0; p < 4; p++) begin
            holdVal <= pat[p][13:7];
            lv <= pat[p][6:0];
            repeat (8) @(posedge clk);
            for (int c = 0; c < 64; c++) begin
                bus(1'b1, `REG_STATUS_SEL_IDX, {24'h0, c[5:0], 2'b00});
                repeat (4) @(posedge clk);
                cmp(statusPin, expPin(c[5:0], holdVal, lv));
            end
        end
        $display("test select codes done");
        // toggling codes 01 to 03, 05, 06, 21 and 22 follow only their own source
        lv <= 7'h00;
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, `REG_STATUS_SEL_IDX, {24'h0, dynCode[i], 2'b00});
            holdVal <= 7'h7F;
            runMask <= 7'h7F ^ (7'h01 << i);
            repeat (8) @(posedge clk);
            n = 0;
            repeat (32) begin
                @(posedge clk);
                n += (statusPin === 1'b1);
            end
            cmp(n, 32);
            runMask <= 7'h01 << i;
            holdVal <= 7'h00;
            repeat (8) @(posedge clk);
            t = 0;
            prev = statusPin;
            repeat (32) begin
                @(posedge clk);
                t += (statusPin !== prev);
                prev = statusPin;
            end
            cmp(t >= 3, 1);
        end
        runMask <= 7'h00;
        $display("test toggling sources done");
        // prescaler moduli for both A counter states
        for (int m = 0; m < 8; m++) begin
            for (int az = 0; az < 2; az++) begin
                aZero <= az[0];
                bus(1'b1, `REG_PRESCALE_IDX, m);
                repeat (40) @(posedge clk);
                period(n);
                cmp(n, expMod(m, az[0]));
                bus(1'b0, `REG_LIVE_STATE_IDX, 0);
                cmp(q & 32'h3F, expMod(m, az[0]));
            end
        end
        $display("test prescaler done");
        // sticky status, mask and read clear
        lv <= 7'h03;
        repeat (8) @(posedge clk);
        bus(1'b0, `REG_INT_STATUS_IDX, 0);
        lv <= 7'h0B;
        repeat (8) @(posedge clk);
        cmp(irq, 0);
        bus(1'b0, `REG_INT_STATUS_IDX, 0);
        cmp(q, 32'h1);
        bus(1'b1, `REG_INT_MASK_IDX, 32'hF);
        bus(1'b0, `REG_INT_MASK_IDX, 0);
        cmp(q, 32'hF);
        lv <= 7'h1B;
        repeat (8) @(posedge clk);
        cmp(irq, 1);
        bus(1'b0, `REG_INT_STATUS_IDX, 0);
        cmp(q, 32'h2);
        repeat (2) @(posedge clk);
        cmp(irq, 0);
        lv <= 7'h0B;
        repeat (8) @(posedge clk);
        bus(1'b0, `REG_INT_STATUS_IDX, 0);
        cmp(q, 32'h0);
        lv <= 7'h2A;
        repeat (8) @(posedge clk);
        bus(1'b0, `REG_INT_STATUS_IDX, 0);
        cmp(q, 32'hC);
        $display("test interrupts done");
        reportAndStop();
    end
endmodule
